// >>> inc/dtc_pkg.sv
// Summary of operation
// RULE1: Timer one gate: run, plus gate input.
// RULE2: Timer one counts clock ticks or pin falls.
// RULE3: Timer zero gate: run, plus gate input.
// RULE4: Timer zero counts clock ticks or pin falls.
// RULE5: Mode bits 5:4 timer one, 1:0 zero.
// RULE6: Timer zero bytes: 16-bit or split 8-bit.
// RULE7: Timer one bytes: 16-bit or 8-bit with reload.
// RULE8: Timer two count as two bytes, reset zero.
// RULE9: Run bits in control register start timers.
// RULE10: Overflow sets flag; vector acknowledge clears it.
// RULE11: Timer two counts clock ticks or pin falls.
// RULE12: Modes: 13-bit, 16-bit, reload, split.
// RULE13: Pins synchronised; fall is high then low.
package dtc_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] DTC_CTRL_ADDR = 8'h88;
  localparam logic [7:0] DTC_TIMER_MODE_CONTROL_ADDR = 8'h89;
  localparam logic [7:0] DTC_TL0_ADDR = 8'h8A;
  localparam logic [7:0] DTC_TL1_ADDR = 8'h8B;
  localparam logic [7:0] DTC_TH0_ADDR = 8'h8C;
  localparam logic [7:0] DTC_TH1_ADDR = 8'h8D;
  localparam logic [7:0] DTC_T2CTL_ADDR = 8'hC8;
  localparam logic [7:0] DTC_TL2_ADDR = 8'hCC;
  localparam logic [7:0] DTC_TH2_ADDR = 8'hCD;
  // ----------------------------------------------------------------
  // Field positions and resets
  // ----------------------------------------------------------------
  localparam int DTC_TIMER_ONE_GATE_SELECT_BIT = 7;
  localparam int DTC_SRC1_BIT = 6;
  localparam int DTC_MODE1_LSB = 4;
  localparam int DTC_TIMER_ZERO_GATE_SELECT_BIT = 3;
  localparam int DTC_SRC0_BIT = 2;
  localparam int DTC_MODE0_LSB = 0;
  localparam int DTC_TF1_BIT = 7;
  localparam int DTC_TR1_BIT = 6;
  localparam int DTC_TF0_BIT = 5;
  localparam int DTC_TR0_BIT = 4;
  localparam int DTC_TR2_BIT = 2;
  localparam int DTC_SRC2_BIT = 1;
  localparam logic [7:0] DTC_REG_RESET = 8'h00;
  // Prescale: system clock divided to the peripheral tick
  localparam int DTC_PRESCALE = 12;
  typedef enum logic [1:0] {
    DTC_MODE_13 = 2'h0,
    DTC_MODE_16 = 2'h1,
    DTC_MODE_RELOAD = 2'h2,
    DTC_MODE_SPLIT = 2'h3
  } dtc_mode_e;
endpackage

// >>> hw/dtc_sync_fall.sv
`timescale 1ns/10ps
module dtc_sync_fall
  import dtc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Pin
  input wire logic pin,
  output logic level,
  output logic fall
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
    end
    else
    begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  assign level = s2_r; // see RULE13
  assign fall = s3_r & ~s2_r; // see RULE13
endmodule // dtc_sync_fall

// >>> hw/dtc_timers.sv
// The plain strobed port was chosen for this implementation.
`timescale 1ns/10ps
module dtc_timers
  import dtc_pkg::*;
#(
  parameter int PRESCALE = DTC_PRESCALE
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Interrupt vector acknowledges
  input wire logic ack_zero,
  input wire logic ack_one,
  // External pins
  input wire logic timer_zero_count_pin,
  input wire logic timer_one_count_pin,
  input wire logic timer_two_count_pin,
  input wire logic ext_gate_input_zero,
  input wire logic ext_gate_input_one,
  // Flags
  output logic timer_zero_overflow_flag,
  output logic timer_one_overflow_flag
);
  import dtc_pkg::*;
  default clocking dtc_cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  // The prescaler register is eight bits wide
  if (PRESCALE < 1 || PRESCALE > 255)
  begin : g_bad_prescale
    $error("PRESCALE out of range");
  end
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] timer_mode_control_r;
  logic [7:0] tl0_r, th0_r, tl1_r, th1_r, tl2_r, th2_r;
  logic tr0_r, tr1_r, tr2_r, src2_r;
  logic [7:0] pre_r;
  logic [7:0] rdata_r;
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic c0_fall, c1_fall, c2_fall, g0_lvl, g1_lvl;
  dtc_sync_fall u_c0 (.mclk(mclk), .nrst(nrst),
    .pin(timer_zero_count_pin), .level(), .fall(c0_fall));
  dtc_sync_fall u_c1 (.mclk(mclk), .nrst(nrst),
    .pin(timer_one_count_pin), .level(), .fall(c1_fall));
  dtc_sync_fall u_c2 (.mclk(mclk), .nrst(nrst),
    .pin(timer_two_count_pin), .level(), .fall(c2_fall));
  dtc_sync_fall u_g0 (.mclk(mclk), .nrst(nrst),
    .pin(ext_gate_input_zero), .level(g0_lvl), .fall());
  dtc_sync_fall u_g1 (.mclk(mclk), .nrst(nrst),
    .pin(ext_gate_input_one), .level(g1_lvl), .fall());
  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire tick = (pre_r == 8'(PRESCALE - 1));
  wire [1:0] mode0 = timer_mode_control_r[DTC_MODE0_LSB +: 2]; // see RULE5
  wire [1:0] mode1 = timer_mode_control_r[DTC_MODE1_LSB +: 2]; // see RULE5
  wire run0 = tr0_r & (~timer_mode_control_r[DTC_TIMER_ZERO_GATE_SELECT_BIT] | g0_lvl); // see RULE3
  wire run1 = tr1_r & (~timer_mode_control_r[DTC_TIMER_ONE_GATE_SELECT_BIT] | g1_lvl); // see RULE1
  wire ev0 = timer_mode_control_r[DTC_SRC0_BIT] ? c0_fall : tick; // see RULE4
  wire ev1 = timer_mode_control_r[DTC_SRC1_BIT] ? c1_fall : tick; // see RULE2
  wire ev2 = src2_r ? c2_fall : tick; // see RULE11
  wire inc0 = run0 & ev0; // see RULE9
  wire inc1 = run1 & ev1 & (mode1 != DTC_MODE_SPLIT); // see RULE12
  // Split mode: high byte of timer zero borrows timer one's run and tick
  wire inc0h = tr1_r & tick;
  wire inc2 = tr2_r & ev2;
  wire w_tl0 = wr & (addr == DTC_TL0_ADDR);
  wire w_th0 = wr & (addr == DTC_TH0_ADDR);
  wire w_tl1 = wr & (addr == DTC_TL1_ADDR);
  wire w_th1 = wr & (addr == DTC_TH1_ADDR);
  wire w_ctl = wr & (addr == DTC_CTRL_ADDR);
  // ----------------------------------------------------------------
  // Counting
  // ----------------------------------------------------------------
  logic [7:0] tl0_nxt, th0_nxt, tl1_nxt, th1_nxt;
  logic ovf0, ovf1;
  // Timer zero, low-nibble owner of mode field
  always_comb
  begin
    tl0_nxt = tl0_r;
    th0_nxt = th0_r;
    ovf0 = 1'b0;
    if (inc0)
    begin
      unique case (mode0)
        DTC_MODE_13:
        begin
          // 5-bit prescaler in low byte, 8 bits above: see RULE12
          tl0_nxt = {tl0_r[7:5], tl0_r[4:0] + 5'h01};
          if (tl0_r[4:0] == 5'h1F)
          begin
            th0_nxt = th0_r + 8'h01;
            ovf0 = (th0_r == 8'hFF);
          end
        end
        DTC_MODE_16:
        begin
          {th0_nxt, tl0_nxt} = {th0_r, tl0_r} + 16'h0001; // see RULE6
          ovf0 = ({th0_r, tl0_r} == 16'hFFFF);
        end
        DTC_MODE_RELOAD:
        begin
          tl0_nxt = (tl0_r == 8'hFF) ? th0_r : tl0_r + 8'h01;
          ovf0 = (tl0_r == 8'hFF);
        end
        DTC_MODE_SPLIT:
        begin
          tl0_nxt = tl0_r + 8'h01; // see RULE6
          ovf0 = (tl0_r == 8'hFF);
        end
      endcase
    end
    if (mode0 == DTC_MODE_SPLIT && inc0h)
      th0_nxt = th0_r + 8'h01;
  end
  // Timer one; halts entirely in split mode
  always_comb
  begin
    tl1_nxt = tl1_r;
    th1_nxt = th1_r;
    ovf1 = 1'b0;
    if (inc1)
    begin
      unique case (mode1)
        DTC_MODE_13:
        begin
          tl1_nxt = {tl1_r[7:5], tl1_r[4:0] + 5'h01};
          if (tl1_r[4:0] == 5'h1F)
          begin
            th1_nxt = th1_r + 8'h01;
            ovf1 = (th1_r == 8'hFF);
          end
        end
        DTC_MODE_16:
        begin
          {th1_nxt, tl1_nxt} = {th1_r, tl1_r} + 16'h0001; // see RULE7
          ovf1 = ({th1_r, tl1_r} == 16'hFFFF);
        end
        DTC_MODE_RELOAD:
        begin
          tl1_nxt = (tl1_r == 8'hFF) ? th1_r : tl1_r + 8'h01; // see RULE7
          ovf1 = (tl1_r == 8'hFF);
        end
        default:
        begin
          tl1_nxt = tl1_r;
        end
      endcase
    end
  end
  // Split mode hands the timer one flag to timer zero's high byte
  wire ovf0h = (mode0 == DTC_MODE_SPLIT) & inc0h & (th0_r == 8'hFF);
  wire set_tf0 = ovf0;
  wire set_tf1 = ovf1 | ovf0h;
  // ----------------------------------------------------------------
  // State update
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      pre_r <= 8'h00;
    else if (tick)
      pre_r <= 8'h00;
    else
      pre_r <= pre_r + 8'h01;
  end
  // Software write wins over a count in the same cycle
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      tl0_r <= DTC_REG_RESET;
      th0_r <= DTC_REG_RESET;
      tl1_r <= DTC_REG_RESET;
      th1_r <= DTC_REG_RESET;
    end
    else
    begin
      tl0_r <= w_tl0 ? wdata : tl0_nxt;
      th0_r <= w_th0 ? wdata : th0_nxt;
      tl1_r <= w_tl1 ? wdata : tl1_nxt;
      th1_r <= w_th1 ? wdata : th1_nxt;
    end
  end
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      {th2_r, tl2_r} <= {DTC_REG_RESET, DTC_REG_RESET}; // see RULE8
    else if (wr && addr == DTC_TL2_ADDR)
      tl2_r <= wdata; // see RULE8
    else if (wr && addr == DTC_TH2_ADDR)
      th2_r <= wdata;
    else if (inc2)
      {th2_r, tl2_r} <= {th2_r, tl2_r} + 16'h0001;
  end
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      timer_mode_control_r <= DTC_REG_RESET;
      tr0_r <= 1'b0;
      tr1_r <= 1'b0;
      tr2_r <= 1'b0;
      src2_r <= 1'b0;
    end
    else
    begin
      if (wr && addr == DTC_TIMER_MODE_CONTROL_ADDR)
        timer_mode_control_r <= wdata;
      if (w_ctl)
      begin
        tr0_r <= wdata[DTC_TR0_BIT]; // see RULE9
        tr1_r <= wdata[DTC_TR1_BIT]; // see RULE9
      end
      if (wr && addr == DTC_T2CTL_ADDR)
      begin
        tr2_r <= wdata[DTC_TR2_BIT];
        src2_r <= wdata[DTC_SRC2_BIT]; // see RULE11
      end
    end
  end
  // Set wins over acknowledge or software write
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      timer_zero_overflow_flag <= 1'b0;
      timer_one_overflow_flag <= 1'b0;
    end
    else
    begin
      if (set_tf0)
        timer_zero_overflow_flag <= 1'b1; // see RULE10
      else if (ack_zero)
        timer_zero_overflow_flag <= 1'b0; // see RULE10
      else if (w_ctl)
        timer_zero_overflow_flag <= wdata[DTC_TF0_BIT];
      if (set_tf1)
        timer_one_overflow_flag <= 1'b1; // see RULE10
      else if (ack_one)
        timer_one_overflow_flag <= 1'b0;
      else if (w_ctl)
        timer_one_overflow_flag <= wdata[DTC_TF1_BIT];
    end
  end
  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [7:0] rsel;
  always_comb
  begin
    unique case (addr)
      DTC_CTRL_ADDR: rsel = {timer_one_overflow_flag, tr1_r,
                             timer_zero_overflow_flag, tr0_r, 4'h0};
      DTC_TIMER_MODE_CONTROL_ADDR: rsel = timer_mode_control_r;
      DTC_TL0_ADDR: rsel = tl0_r;
      DTC_TL1_ADDR: rsel = tl1_r;
      DTC_TH0_ADDR: rsel = th0_r;
      DTC_TH1_ADDR: rsel = th1_r;
      DTC_T2CTL_ADDR: rsel = {5'h00, tr2_r, src2_r, 1'b0};
      DTC_TL2_ADDR: rsel = tl2_r;
      DTC_TH2_ADDR: rsel = th2_r;
      default: rsel = 8'h00;
    endcase
  end
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      rdata_r <= 8'h00;
    else if (rd)
      rdata_r <= rsel;
    else
      rdata_r <= 8'h00;
  end
  assign rdata = rdata_r;
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_ovf16_0;
    mode0 == DTC_MODE_16 && inc0 && {th0_r, tl0_r} == 16'hFFFF;
  endsequence
  // A count pin fall needs three edges to reach the counter
  sequence s_fall_zero;
    timer_zero_count_pin ##1 !timer_zero_count_pin;
  endsequence
  ovf_flag_a: assert property // see RULE10
    (s_ovf16_0 |=> timer_zero_overflow_flag)
    else $error("overflow flag not set");
  gate_hold_a: assert property // see RULE3
    (timer_mode_control_r[DTC_TIMER_ZERO_GATE_SELECT_BIT] && !g0_lvl && !w_tl0 && mode0 != DTC_MODE_SPLIT
    |=> $stable(tl0_r))
    else $error("gated timer zero counted");
  gate_one_a: assert property // see RULE1
    (!tr1_r && !w_tl1 |=> $stable(tl1_r))
    else $error("stopped timer one counted");
  split_stop_a: assert property // see RULE12
    (mode1 == DTC_MODE_SPLIT && !w_tl1 && !w_th1
    |=> $stable({th1_r, tl1_r}))
    else $error("timer one ran in split mode");
  reload_a: assert property // see RULE7
    (mode1 == DTC_MODE_RELOAD && inc1 && tl1_r == 8'hFF && !w_tl1
    |=> tl1_r == $past(th1_r))
    else $error("reload value wrong");
  src_ext_a: assert property // see RULE4
    (timer_mode_control_r[DTC_SRC0_BIT] && !c0_fall |-> !inc0)
    else $error("timer zero counted without pin fall");
  src_one_a: assert property // see RULE2
    (timer_mode_control_r[DTC_SRC1_BIT] && !c1_fall |-> !inc1)
    else $error("timer one counted without pin fall");
  t2_count_a: assert property // see RULE11
    (inc2 && !wr |=> {th2_r, tl2_r} == $past({th2_r, tl2_r}) + 16'h0001)
    else $error("timer two did not count");
  fall_seen_a: assert property // see RULE13
    (s_fall_zero |=> ##1 c0_fall)
    else $error("count pin fall not seen");
  gate_ext_a: assert property // see RULE1
    (timer_mode_control_r[DTC_TIMER_ONE_GATE_SELECT_BIT] && !g1_lvl && !w_tl1 |=> $stable(tl1_r))
    else $error("gated timer one counted");
  run_stop_a: assert property // see RULE9
    (!tr0_r && !w_tl0 |=> $stable(tl0_r))
    else $error("stopped timer zero counted");
  ack_clear_a: assert property // see RULE10
    (ack_zero && !set_tf0 |=> !timer_zero_overflow_flag)
    else $error("acknowledge did not clear flag");
  split_high_a: assert property // see RULE12
    (mode0 == DTC_MODE_SPLIT && inc0h && !w_th0
    |=> th0_r == $past(th0_r) + 8'h01)
    else $error("split high byte did not count");
  split_flag_a: assert property // see RULE12
    (ovf0h |=> timer_one_overflow_flag)
    else $error("split overflow flag not set");
  m13_hold_a: assert property // see RULE12
    (mode0 == DTC_MODE_13 && !w_tl0
    |=> tl0_r[7:5] == $past(tl0_r[7:5]))
    else $error("mode zero upper bits moved");
  rd_two_a: assert property // see RULE8
    (rd && addr == DTC_TL2_ADDR |=> rdata == $past(tl2_r))
    else $error("timer two read wrong");
endmodule // dtc_timers

// >>> tb/dtc_pin_model.sv
`timescale 1ns/10ps
module dtc_pin_model (
  // Clock
  input wire logic mclk,
  // Request
  input wire logic go,
  input wire logic [1:0] sel,
  input wire logic [7:0] n_falls,
  input wire logic slow,
  // Pins
  output logic [2:0] pins,
  output logic busy
);
  int hold;

  // Pins idle high as on a pulled-up port line
  initial
  begin
    pins = 3'h7;
    busy = 1'b0;
  end

  // ----------------------------------------------------------------
  // Fall generator
  // ----------------------------------------------------------------
  // Each level is held several clocks so the synchroniser sees it
  always
  begin
    @(posedge mclk);
    if (go)
    begin
      busy <= 1'b1;
      hold = slow ? 6 : 3;
      for (int i = 0; i < n_falls; i++)
      begin
        pins[sel] <= 1'b0;
        repeat (hold) @(posedge mclk);
        pins[sel] <= 1'b1;
        repeat (hold) @(posedge mclk);
      end
      busy <= 1'b0;
    end
  end
endmodule // dtc_pin_model

// >>> tb/tb.sv
`timescale 1ns/10ps
module tb;
  import dtc_pkg::*;
  logic mclk, nrst, wr, rd, ack_zero, ack_one, go, slow, busy;
  logic [7:0] addr, wdata, rdata, n_falls;
  logic ext_gate_input_zero, ext_gate_input_one;
  logic timer_zero_overflow_flag, timer_one_overflow_flag;
  logic [1:0] sel;
  logic [2:0] pins;
  int n_errors, cmp_count, cycles;
  logic [7:0] map [9] = '{DTC_CTRL_ADDR, DTC_TIMER_MODE_CONTROL_ADDR, DTC_TL0_ADDR,
    DTC_TL1_ADDR, DTC_TH0_ADDR, DTC_TH1_ADDR, DTC_T2CTL_ADDR,
    DTC_TL2_ADDR, DTC_TH2_ADDR};

  // Short prescale keeps tick tests brief
  dtc_timers #(.PRESCALE(4)) dut (
    .mclk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .ack_zero, .ack_one,
    .timer_zero_count_pin(pins[0]),
    .timer_one_count_pin(pins[1]),
    .timer_two_count_pin(pins[2]),
    .ext_gate_input_zero, .ext_gate_input_one,
    .timer_zero_overflow_flag, .timer_one_overflow_flag
  );

  dtc_pin_model pm (
    .mclk, .go, .sel, .n_falls, .slow, .pins, .busy
  );

  always #50 mclk = ~mclk;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), exp, rdata);
  endtask

  task automatic fchk(input logic z, input logic exp);
    @(posedge mclk);
    #1;
    if (z)
      chk("flag zero", {7'h0, exp}, {7'h0, timer_zero_overflow_flag});
    else
      chk("flag one", {7'h0, exp}, {7'h0, timer_one_overflow_flag});
  endtask

  task automatic ack(input logic z);
    @(posedge mclk);
    ack_zero <= z;
    ack_one <= !z;
    @(posedge mclk);
    ack_zero <= 1'b0;
    ack_one <= 1'b0;
  endtask

  // Waits for the model, then for the synchroniser to settle
  task automatic fall(input logic [1:0] s, input logic [7:0] n,
                      input logic sl);
    @(posedge mclk);
    go <= 1'b1;
    sel <= s;
    n_falls <= n;
    slow <= sl;
    @(posedge mclk);
    go <= 1'b0;
    @(posedge mclk);
    for (int k = 0; k < 400 && busy; k++) @(posedge mclk);
    repeat (4) @(posedge mclk);
  endtask

  // ----------------------------------------------------------------
  // Hang guard
  // ----------------------------------------------------------------
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {mclk, nrst, wr, rd, ack_zero, ack_one, go, slow} = 8'h00;
    {addr, wdata, n_falls, sel} = 26'h0;
    {ext_gate_input_zero, ext_gate_input_one} = 2'h0;
    {n_errors, cmp_count, cycles} = 96'h0;
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    foreach (map[i]) rchk(map[i], DTC_REG_RESET);
    wreg(8'h90, 8'hA5);
    rchk(8'h90, 8'h00);
    $display("Test reset done");
    wreg(DTC_TIMER_MODE_CONTROL_ADDR, 8'h05);
    rchk(DTC_TIMER_MODE_CONTROL_ADDR, 8'h05);
    fall(0, 2, 0);
    rchk(DTC_TL0_ADDR, 8'h00);
    wreg(DTC_CTRL_ADDR, 8'h10);
    wreg(DTC_TL0_ADDR, 8'hFE);
    wreg(DTC_TH0_ADDR, 8'h12);
    fall(0, 3, 0);
    rchk(DTC_TL0_ADDR, 8'h01);
    rchk(DTC_TH0_ADDR, 8'h13);
    wreg(DTC_TIMER_MODE_CONTROL_ADDR, 8'h0D);
    fall(0, 2, 0);
    rchk(DTC_TL0_ADDR, 8'h01);
    @(posedge mclk);
    ext_gate_input_zero <= 1'b1;
    fall(0, 2, 1);
    rchk(DTC_TL0_ADDR, 8'h03);
    $display("Test counter zero done");
    wreg(DTC_TIMER_MODE_CONTROL_ADDR, 8'h04);
    wreg(DTC_TL0_ADDR, 8'h1E);
    wreg(DTC_TH0_ADDR, 8'hFF);
    fall(0, 2, 0);
    rchk(DTC_TL0_ADDR, 8'h00);
    rchk(DTC_TH0_ADDR, 8'h00);
    rchk(DTC_CTRL_ADDR, 8'h30);
    ack(1'b1);
    fchk(1'b1, 1'b0);
    $display("Test mode zero done");
    wreg(DTC_TIMER_MODE_CONTROL_ADDR, 8'hE0);
    wreg(DTC_TH1_ADDR, 8'hFE);
    wreg(DTC_TL1_ADDR, 8'hFE);
    wreg(DTC_CTRL_ADDR, 8'h40);
    fall(1, 2, 0);
    rchk(DTC_TL1_ADDR, 8'hFE);
    @(posedge mclk);
    ext_gate_input_one <= 1'b1;
    fall(1, 3, 0);
    rchk(DTC_TL1_ADDR, 8'hFF);
    rchk(DTC_TH1_ADDR, 8'hFE);
    fchk(1'b0, 1'b1);
    ack(1'b0);
    fchk(1'b0, 1'b0);
    $display("Test reload one done");
    // Run bits first: a control write also clears the flags
    wreg(DTC_TIMER_MODE_CONTROL_ADDR, 8'h37);
    wreg(DTC_CTRL_ADDR, 8'h50);
    wreg(DTC_TL0_ADDR, 8'h00);
    wreg(DTC_TH0_ADDR, 8'hFF);
    fall(0, 2, 0);
    rchk(DTC_TL0_ADDR, 8'h02);
    fchk(1'b0, 1'b1);
    rchk(DTC_TL1_ADDR, 8'hFF);
    $display("Test split done");
    wreg(DTC_CTRL_ADDR, 8'h00);
    wreg(DTC_TIMER_MODE_CONTROL_ADDR, 8'h01);
    wreg(DTC_TL0_ADDR, 8'hFE);
    wreg(DTC_TH0_ADDR, 8'hFF);
    fchk(1'b1, 1'b0);
    wreg(DTC_CTRL_ADDR, 8'h10);
    repeat (16) @(posedge mclk);
    fchk(1'b1, 1'b1);
    $display("Test tick zero done");
    wreg(DTC_T2CTL_ADDR, 8'h06);
    fall(2, 4, 1);
    rchk(DTC_TL2_ADDR, 8'h04);
    rchk(DTC_TH2_ADDR, 8'h00);
    wreg(DTC_TH2_ADDR, 8'hAB);
    rchk(DTC_TH2_ADDR, 8'hAB);
    $display("Test timer two done");
    // Eight edges of run time hold exactly two ticks at prescale 4
    wreg(DTC_TL2_ADDR, 8'hFF);
    wreg(DTC_T2CTL_ADDR, 8'h04);
    repeat (6) @(posedge mclk);
    wreg(DTC_T2CTL_ADDR, 8'h00);
    rchk(DTC_TL2_ADDR, 8'h01);
    rchk(DTC_TH2_ADDR, 8'hAC);
    $display("Test tick two done");
    wreg(DTC_CTRL_ADDR, 8'h00);
    wreg(DTC_TIMER_MODE_CONTROL_ADDR, 8'h56);
    wreg(DTC_TL0_ADDR, 8'hFF);
    wreg(DTC_TH0_ADDR, 8'h80);
    wreg(DTC_TL1_ADDR, 8'hFF);
    wreg(DTC_TH1_ADDR, 8'h12);
    wreg(DTC_CTRL_ADDR, 8'h50);
    fall(0, 2, 0);
    rchk(DTC_TL0_ADDR, 8'h81);
    rchk(DTC_TH0_ADDR, 8'h80);
    fchk(1'b1, 1'b1);
    fall(1, 1, 0);
    rchk(DTC_TL1_ADDR, 8'h00);
    rchk(DTC_TH1_ADDR, 8'h13);
    fchk(1'b0, 1'b0);
    $display("Test more modes done");
    wrap_up();
  end
endmodule // tb
